// *** logic/qdc_params.svh ***
`ifndef QDC_PARAMS_SVH
`define QDC_PARAMS_SVH

// word layout, msb first
`define QDC_WORD_W 12
`define QDC_DATA_W 8
`define QDC_NCHAN 4
`define QDC_SR_RST 12'h000
`define QDC_DATA_RST 8'h00
// link input synchroniser depth
`define QDC_SYNC_W 3
// command codes on {chan_sel, ctrl_code}
`define QDC_CMD_NOP 4'h0
`define QDC_CMD_SW_LOAD 4'h4
`define QDC_CMD_LOAD_ALL 4'h8
`define QDC_CMD_SHUTDOWN 4'hc
`define QDC_CMD_USER_LOW 4'h2
`define QDC_CMD_USER_HIGH 4'h6
`define QDC_CMD_PH_RISE 4'he
`define QDC_CMD_PH_FALL 4'ha
// ctrl_code values
`define QDC_CTRL_INPUT 2'h1
`define QDC_CTRL_BOTH 2'h3

`endif

// *** logic/qdc_pkg.sv ***
package qdc_pkg;

	typedef struct packed {
		logic [1:0] chan_sel;
		logic [1:0] ctrl_code;
		logic [7:0] data;
	} qdc_word_t;

	typedef logic [3:0][7:0] qdc_bank_t;

	typedef enum logic [1:0] {
		QDC_IDLE = 2'h0,
		QDC_SHIFT = 2'h1
	} qdc_state_t;

endpackage

// *** logic/qdc_decoder.sv ***
`include "qdc_params.svh"
// What this block does
// - word is 12 bits msb first: channel, control, then data byte
// - execute shift register contents only at chip select rising edge
// - reset clears interface and codes, selects falling-edge serial_out
// - serial_out lags input 12.5 cycles falling mode, 12 rising mode
// - channel bits 0..3 select channels a, b, c, d
// - control 01 loads selected input register only, dac untouched
// - control 11 loads input register then updates all dacs
// - 0100 copies inputs to dacs and leaves shutdown
// - software transfer equals load_outputs_n low, timed at chip select
// - 1000 writes data to all dacs and leaves shutdown
// - 1000 with zero data clears every dac
// - 1100 enters shutdown only while power_down_allow is high
// - 0010 drives user output low, 0110 high, level held
// - 0000 changes nothing, bits pass toward serial_out
// - 1110 selects rising-edge serial_out and copies inputs to dacs
// - 1010 selects falling-edge serial_out and copies inputs to dacs
// - serial_out phase held until reset or opposite phase command
module qdc_decoder (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	input wire logic load_outputs_n_i,
	input wire logic clear_all_n_i,
	input wire logic power_down_allow_i,
	output logic serial_out_o,
	output logic user_logic_out_o,
	output logic shutdown_o,
	output logic rise_mode_o,
	output qdc_pkg::qdc_bank_t input_reg_o,
	output qdc_pkg::qdc_bank_t dac_reg_o
);

	////////////////////////////////////////////////////////////////
	// link input synchronisers

	logic [`QDC_SYNC_W-1:0] sclk_sync;
	logic [`QDC_SYNC_W-1:0] cs_sync;
	logic [`QDC_SYNC_W-1:0] sdi_sync;
	logic [`QDC_SYNC_W-1:0] load_outputs_n_sync;
	logic [`QDC_SYNC_W-1:0] clr_sync;
	logic [`QDC_SYNC_W-1:0] pda_sync;
	logic sclk_lvl;
	logic cs_lvl;
	logic sdi_lvl;
	logic load_outputs_n_lvl;
	logic clr_lvl;
	logic pda_lvl;

	// three flops per pin, level moves when last two agree
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sclk_sync <= '0;
			cs_sync <= '1;
			sdi_sync <= '0;
			load_outputs_n_sync <= '1;
			clr_sync <= '1;
			pda_sync <= '0;
		end
		else
		begin
			sclk_sync <= {sclk_sync[1:0], sclk_i};
			cs_sync <= {cs_sync[1:0], cs_n_i};
			sdi_sync <= {sdi_sync[1:0], sdi_i};
			load_outputs_n_sync <= {load_outputs_n_sync[1:0], load_outputs_n_i};
			clr_sync <= {clr_sync[1:0], clear_all_n_i};
			pda_sync <= {pda_sync[1:0], power_down_allow_i};
		end
	end

	// filtered levels
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sclk_lvl <= 1'b0;
			cs_lvl <= 1'b1;
			sdi_lvl <= 1'b0;
			load_outputs_n_lvl <= 1'b1;
			clr_lvl <= 1'b1;
			pda_lvl <= 1'b0;
		end
		else
		begin
			if (sclk_sync[1] == sclk_sync[2])
				sclk_lvl <= sclk_sync[2];
			if (cs_sync[1] == cs_sync[2])
				cs_lvl <= cs_sync[2];
			if (sdi_sync[1] == sdi_sync[2])
				sdi_lvl <= sdi_sync[2];
			if (load_outputs_n_sync[1] == load_outputs_n_sync[2])
				load_outputs_n_lvl <= load_outputs_n_sync[2];
			if (clr_sync[1] == clr_sync[2])
				clr_lvl <= clr_sync[2];
			if (pda_sync[1] == pda_sync[2])
				pda_lvl <= pda_sync[2];
		end
	end

	////////////////////////////////////////////////////////////////
	// edge detection

	logic sclk_new;
	logic cs_new;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;

	assign sclk_new = (sclk_sync[1] == sclk_sync[2]) ? sclk_sync[2] : sclk_lvl;
	assign cs_new = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_lvl;
	assign sclk_rise = sclk_new & ~sclk_lvl;
	assign sclk_fall = ~sclk_new & sclk_lvl;
	assign cs_rise = cs_new & ~cs_lvl;

	////////////////////////////////////////////////////////////////
	// shift register and frame state

	qdc_pkg::qdc_state_t state;
	logic [`QDC_WORD_W-1:0] shreg;
	qdc_pkg::qdc_word_t word;
	logic shift_en;

	assign shift_en = (state == qdc_pkg::QDC_SHIFT) && sclk_rise && !cs_new;
	assign word = qdc_pkg::qdc_word_t'(shreg);

	// frame tracking from chip select
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			state <= qdc_pkg::QDC_IDLE;
		else
		begin
			unique case (state)
				qdc_pkg::QDC_IDLE:
					if (!cs_new)
						state <= qdc_pkg::QDC_SHIFT;
				qdc_pkg::QDC_SHIFT:
					if (cs_new)
						state <= qdc_pkg::QDC_IDLE;
			endcase
		end
	end

	// msb first sampling on rising sclk
	// older bits fall off the top
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			shreg <= `QDC_SR_RST;
		else if (!clr_lvl)
			shreg <= `QDC_SR_RST;
		else if (shift_en)
			shreg <= {shreg[`QDC_WORD_W-2:0], sdi_lvl};
	end

	////////////////////////////////////////////////////////////////
	// serial output

	logic rise_mode;
	logic spill;

	// bit leaving the msb, held for the following falling edge
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			spill <= 1'b0;
		else if (shift_en)
			spill <= shreg[`QDC_WORD_W-1];
	end

	// rising mode: msb out on same edge, falling: half cycle later
	// nop words simply pass through here
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			serial_out_o <= 1'b0;
		else if (!cs_new && (rise_mode ? sclk_rise : sclk_fall))
			serial_out_o <= rise_mode ? shreg[`QDC_WORD_W-1] : spill;
	end

	////////////////////////////////////////////////////////////////
	// command decode

	logic [3:0] cmd;
	logic [1:0] chan;
	logic do_input;
	logic do_xfer;
	logic do_all;

	assign cmd = {word.chan_sel, word.ctrl_code};
	assign chan = word.chan_sel;
	assign do_input = cs_rise && (word.ctrl_code == `QDC_CTRL_INPUT
		|| word.ctrl_code == `QDC_CTRL_BOTH);
	assign do_xfer = (cs_rise && (word.ctrl_code == `QDC_CTRL_BOTH
		|| cmd == `QDC_CMD_SW_LOAD || cmd == `QDC_CMD_PH_RISE
		|| cmd == `QDC_CMD_PH_FALL)) || !load_outputs_n_lvl;
	assign do_all = cs_rise && cmd == `QDC_CMD_LOAD_ALL;

	// per channel storage
	generate
		for (genvar i = 0; i < `QDC_NCHAN; i++)
		begin : g_chan
			logic sel;
			logic [`QDC_DATA_W-1:0] next_in;
			assign sel = do_input && chan == 2'(i);
			assign next_in = sel ? word.data : input_reg_o[i];

			// input register
			always_ff @(posedge clk_i or negedge nrst_i)
			begin
				if (!nrst_i)
					input_reg_o[i] <= `QDC_DATA_RST;
				else if (!clr_lvl)
					input_reg_o[i] <= `QDC_DATA_RST;
				else
					input_reg_o[i] <= next_in;
			end

			always_ff @(posedge clk_i or negedge nrst_i)
			begin
				if (!nrst_i)
					dac_reg_o[i] <= `QDC_DATA_RST;
				else if (!clr_lvl)
					dac_reg_o[i] <= `QDC_DATA_RST;
				else if (do_all)
					dac_reg_o[i] <= word.data;
				else if (do_xfer)
					dac_reg_o[i] <= next_in;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// mode flags

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			shutdown_o <= 1'b0;
		else if (cs_rise && cmd == `QDC_CMD_SHUTDOWN && pda_lvl)
			shutdown_o <= 1'b1;
		else if (cs_rise && (cmd == `QDC_CMD_SW_LOAD || cmd == `QDC_CMD_LOAD_ALL))
			shutdown_o <= 1'b0;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			user_logic_out_o <= 1'b0;
		else if (cs_rise && cmd == `QDC_CMD_USER_LOW)
			user_logic_out_o <= 1'b0;
		else if (cs_rise && cmd == `QDC_CMD_USER_HIGH)
			user_logic_out_o <= 1'b1;
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rise_mode <= 1'b0;
		else if (cs_rise && cmd == `QDC_CMD_PH_RISE)
			rise_mode <= 1'b1;
		else if (cs_rise && cmd == `QDC_CMD_PH_FALL)
			rise_mode <= 1'b0;
	end

	assign rise_mode_o = rise_mode;

endmodule

// *** dv/qdc_decoder_sva.sv ***
// checker on the decoder's own pins
module qdc_decoder_sva (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	input wire logic load_outputs_n_i,
	input wire logic clear_all_n_i,
	input wire logic power_down_allow_i,
	input wire logic serial_out_o,
	input wire logic user_logic_out_o,
	input wire logic shutdown_o,
	input wire logic rise_mode_o,
	input wire qdc_pkg::qdc_bank_t input_reg_o,
	input wire qdc_pkg::qdc_bank_t dac_reg_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	////////////////////////////////////////////////////////////////
	a_reset_state: assert property ($rose(nrst_i) |-> !rise_mode_o && !shutdown_o
		&& dac_reg_o == '0 && input_reg_o == '0) else $error("state after reset");
	a_idle_regs: assert property ((cs_n_i && clear_all_n_i)[*8] |=>
		$stable(input_reg_o)) else $error("input regs moved while idle");
	a_idle_dacs: assert property ((cs_n_i && clear_all_n_i && load_outputs_n_i)[*8]
		|=> $stable(dac_reg_o)) else $error("dac regs moved while idle");
	a_pin_follow: assert property ((!load_outputs_n_i && clear_all_n_i)[*8] |->
		dac_reg_o == input_reg_o) else $error("dacs not following");
	a_sd_allowed: assert property ($rose(shutdown_o) |->
		$past(power_down_allow_i)) else $error("shutdown not allowed");
	a_sd_keep: assert property ($fell(shutdown_o) |->
		$stable(input_reg_o)) else $error("input regs lost on wake");
	a_phase_cs: assert property ($changed(rise_mode_o) |->
		cs_n_i && $past(cs_n_i, 3)) else $error("phase moved off select");
	a_user_cs: assert property ($changed(user_logic_out_o) |->
		cs_n_i && $past(cs_n_i, 3)) else $error("user out moved off select");
	a_out_hold: assert property (cs_n_i[*6] |=>
		$stable(serial_out_o)) else $error("serial out moved while idle");
endmodule
bind qdc_decoder qdc_decoder_sva qdc_decoder_sva_i (.clk_i, .nrst_i, .sclk_i, .cs_n_i,
	.sdi_i, .load_outputs_n_i, .clear_all_n_i, .power_down_allow_i, .serial_out_o,
	.user_logic_out_o, .shutdown_o, .rise_mode_o, .input_reg_o, .dac_reg_o);

// *** dv/qdc_host.sv ***
// host side serial master, clock idles low
module qdc_host (
	input wire logic clk_i,
	input wire logic serial_out_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdi_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [11:0] rx_r;
	logic [11:0] rx_f;
	// idle levels
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	task tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task open_f;
		cs_n_o = 1'b0;
		tick(4);
	endtask
	// msb first, sample out before each edge
	task word(input logic [11:0] w);
		for (int i = 11; i >= 0; i--)
		begin
			sdi_o = w[i];
			tick(4);
			rx_r = {rx_r[10:0], serial_out_i};
			sclk_o = 1'b1;
			tick(4);
			rx_f = {rx_f[10:0], serial_out_i};
			sclk_o = 1'b0;
		end
	endtask
	// released data line shows the inverse
	task close_f;
		tick(4);
		rx_r = {rx_r[10:0], serial_out_i};
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
		tick(10);
	endtask
endmodule

// *** dv/tb_qdc_decoder.sv ***
module tb_qdc_decoder;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i, nrst_i, ldn, clrn, pda, sclk, cs_n, sdi, so, user_logic_out, sd, rm;
	qdc_pkg::qdc_bank_t inr, dac, e;
	int err_count, num_checks;
	qdc_decoder qdc_decoder_i (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.sdi_i(sdi), .load_outputs_n_i(ldn), .clear_all_n_i(clrn), .power_down_allow_i(pda),
		.serial_out_o(so), .user_logic_out_o(user_logic_out), .shutdown_o(sd), .rise_mode_o(rm),
		.input_reg_o(inr), .dac_reg_o(dac));
	qdc_host qdc_host_i (.clk_i(clk_i), .serial_out_i(so), .sclk_o(sclk), .cs_n_o(cs_n),
		.sdi_o(sdi));
	// 50 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x)
		begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, x, g);
		end
	endtask
	task cmd(input logic [11:0] w);
		qdc_host_i.open_f();
		qdc_host_i.word(w);
		qdc_host_i.close_f();
	endtask
	task exp(input logic [11:0] w, input qdc_pkg::qdc_bank_t x, input logic [2:0] f);
		cmd(w);
		chk("dac", x, dac);
		chk("inreg", e, inr);
		chk("flags", 32'(f), 32'({sd, user_logic_out, rm}));
	endtask
	task t_load;
		for (int c = 0; c < 4; c++)
		begin
			e[c] = {c[3:0], 4'ha};
			cmd({c[1:0], ((c == 3) ? 2'h3 : 2'h1), e[c]});
			chk("dac", (c == 3) ? e : 32'h0, dac);
			chk("inreg", e, inr);
		end
		$display("t_load done");
	endtask
	task t_cmd;
		exp(12'hc00, e, 3'h0);
		pda = 1'b1;
		exp(12'hc00, e, 3'h4);
		e[0] = 8'h77;
		exp(12'h177, 32'h3a2a1a0a, 3'h4);
		exp(12'h4ff, e, 3'h0);
		exp(12'h85a, {4{8'h5a}}, 3'h0);
		exp(12'h800, 32'h0, 3'h0);
		exp(12'h600, 32'h0, 3'h2);
		exp(12'h200, 32'h0, 3'h0);
		exp(12'h0ff, 32'h0, 3'h0);
		exp(12'he00, e, 3'h1);
		exp(12'ha00, e, 3'h0);
		$display("t_cmd done");
	endtask
	task t_chain(input logic m);
		qdc_host_i.open_f();
		qdc_host_i.word(12'h8ff);
		qdc_host_i.word(12'h5c3);
		qdc_host_i.close_f();
		chk("dac", e, dac);
		e[1] = 8'hc3;
		chk("inreg", e, inr);
		chk("dout", 32'h8ff, 32'(qdc_host_i.rx_r));
		// sampled with sclk high: falling mode trails by half a cycle
		chk("dout_ph", m ? 32'h8ff : 32'h47f, m ? 32'(qdc_host_i.rx_f) : 32'(qdc_host_i.rx_f[10:0]));
		chk("mode", 32'(m), 32'(rm));
		$display("t_chain done");
	endtask
	task t_pins;
		ldn = 1'b0;
		e[3] = 8'h42;
		cmd(12'hd42);
		chk("dac", e, dac);
		ldn = 1'b1;
		clrn = 1'b0;
		qdc_host_i.tick(8);
		chk("clear", 32'h0, dac | inr);
		clrn = 1'b1;
		$display("t_pins done");
	endtask
	task finish_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// main sequence
	initial
	begin
		{nrst_i, pda, ldn, clrn, e, err_count, num_checks} = {2'b00, 2'b11, 96'h0};
		repeat (10) @(posedge clk_i);
		#1;
		nrst_i = 1'b1;
		qdc_host_i.tick(5);
		chk("flags", 32'h0, 32'({sd, user_logic_out, rm}));
		chk("dac", 32'h0, dac);
		chk("inreg", 32'h0, inr);
		pda = 1'b0;
		t_load();
		t_cmd();
		t_chain(1'b0);
		exp(12'he00, e, 3'h1);
		t_chain(1'b1);
		t_pins();
		finish_test();
	end
	// watchdog
	initial
	begin
		#500000;
		err_count++;
		finish_test();
	end
endmodule
